// file: hw/bpf_pkg.sv
// package: register map, field positions, reset values and timing constants of the fault/control core
// assumes: one 50 MHz clock; every other rate is derived from it or from the watchdog input
package bpf_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte registers on a plain port)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_HOST_OUT = 8'h01;
   localparam logic [7:0] ADDR_STATE    = 8'h02;
   localparam logic [7:0] ADDR_FEATURE  = 8'h03;
   localparam logic [7:0] ADDR_PICKER   = 8'h04;
   localparam logic [7:0] ADDR_OL_THR   = 8'h05;
   localparam logic [7:0] ADDR_OL_DLY   = 8'h06;
   localparam logic [7:0] ADDR_CHG_SC   = 8'h07;
   localparam logic [7:0] ADDR_DSG_SC   = 8'h08;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int ST_DSG_SHORT  = 0;
   localparam int ST_CHG_SHORT  = 1;
   localparam int ST_OVERLOAD   = 2;
   localparam int ST_WDOG       = 3;
   localparam int ST_SLEEP      = 4;
   localparam int HO_LATCH_CLR  = 0;
   localparam int HO_DSG        = 1;
   localparam int HO_CHG        = 2;
   localparam int HO_ZERO_VOLT_CHARGE_FET_DRIVE      = 3;
   localparam int HO_OPEN_DRAIN = 4;
   localparam int FC_MON_EN     = 0;
   localparam int FC_THERM      = 5;
   localparam int PK_CODE_LO    = 0;
   localparam int PK_CAL_LO     = 2;
   localparam int PK_BAL_LO     = 4;
   localparam int SC_THR_LO     = 4;

   // ---------------------------------------------------------------
   // reset value and reference select codes
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_REG  = 8'h00;
   localparam logic [1:0] CAL_REF_DIRECT = 2'h3;
   localparam logic [1:0] CAL_REF_SCALED = 2'h2;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ          = 50_000_000;
   localparam int STARTUP_MS      = 700;
   localparam int STOP_US         = 100;
   localparam int STARTUP_CYCLES  = STARTUP_MS * (CLK_HZ / 1000);
   localparam int STOP_CYCLES     = STOP_US * (CLK_HZ / 1_000_000);
   localparam int OL_BASE_MS      = 1;
   localparam int OL_STEP_MS      = 2;
   localparam int SC_STEP_US      = 61;
   // watchdog ticks per time unit at the nominal host clock
   localparam int TICKS_PER_MS    = 33;
   localparam int TICKS_PER_SC    = 2;
endpackage : bpf_pkg

// file: hw/bpf_fault_ctrl.sv
// protection fault latching, blanking timers, watchdog and host output control
// assumes: synchronous inputs, single clock, register port with one-cycle strobes
`timescale 1ns/1ns
`default_nettype none
module bpf_fault_ctrl #(
   parameter int STARTUP_CYCLES = bpf_pkg::STARTUP_CYCLES,
   parameter int STOP_CYCLES    = bpf_pkg::STOP_CYCLES,
   parameter int TICKS_PER_MS   = bpf_pkg::TICKS_PER_MS,
   parameter int TICKS_PER_SC   = bpf_pkg::TICKS_PER_SC
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   // analog front end and pins
   input  wire logic       watchdogClockInput,
   input  wire logic       dischargeShortDetect,
   input  wire logic       chargeShortDetect,
   input  wire logic       excessLoadDetect,
   input  wire logic       sleepPin,
   input  wire logic       zeroVoltChargeSelect,
   // FET drives, alert and auxiliary outputs
   output logic            dischargeFetDrive,
   output logic            chargeFetDrive,
   output logic            zeroVoltChargeFetDrive,
   output logic            alertOutputN,
   output logic            openDrainOutput,
   output logic            thermistorDrive,
   // monitor and threshold settings to the analog side
   output logic      [1:0] elementCode,
   output logic      [1:0] calibSelect,
   output logic            monitorEnable,
   output logic            refDirectRoute,
   output logic            refScaledRoute,
   output logic      [3:0] balanceEnable,
   output logic      [4:0] overloadThresholdSetting,
   output logic      [3:0] chargeShortSetting,
   output logic      [3:0] dischargeShortSetting
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      WD_WAIT = 3'b001,
      WD_RUN  = 3'b010,
      WD_STOP = 3'b100
   } bpf_wd_e;

   logic [4:0]  hostCtl;
   logic [7:0]  stateCtl;
   logic [7:0]  featureCtl;
   logic [7:0]  picker;
   logic [7:0]  olThr;
   logic [7:0]  olDly;
   logic [7:0]  chgSc;
   logic [7:0]  dsgSc;
   logic [2:0]  faultFlag;
   logic        wdogFlag;
   logic        alertPend;
   logic        initState;
   logic        pmsStrap;
   logic        strapDone;
   logic        wdiPrev;
   logic        sleepPrev;
   bpf_wd_e     wdState;
   logic [25:0] startCnt;
   logic        startExpired;
   logic [12:0] gapCnt;
   logic [10:0] blankCnt [3];
   logic [10:0] blankLim [3];
   logic [2:0]  detect;
   logic [2:0]  faultSet;
   logic        wdiTick;
   logic        clrPulse;
   logic        wrHit;
   logic        statusRead;
   logic        wdEvent;
   logic        wdActive;
   logic        protOk;
   logic        alertSet;
   logic [7:0]  statusWord;
   logic        next_dsg;
   logic        next_chg;
   logic        next_zv;

   assign wrHit      = regWr;
   assign statusRead = regRd && (regAddr == bpf_pkg::ADDR_STATUS);
   assign wdiTick    = watchdogClockInput && !wdiPrev;
   // only a 1 -> 0 write after a 0 -> 1 write clears; the bit resets to 0
   assign clrPulse   = wrHit && (regAddr == bpf_pkg::ADDR_HOST_OUT)
                     && !regWrData[bpf_pkg::HO_LATCH_CLR] && hostCtl[bpf_pkg::HO_LATCH_CLR];

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hostCtl    <= 5'h00;
         stateCtl   <= bpf_pkg::RST_REG;
         featureCtl <= bpf_pkg::RST_REG;
         picker     <= bpf_pkg::RST_REG;
         olThr      <= bpf_pkg::RST_REG;
         olDly      <= bpf_pkg::RST_REG;
         chgSc      <= bpf_pkg::RST_REG;
         dsgSc      <= bpf_pkg::RST_REG;
      end else if (wrHit) begin
         unique case (regAddr)
            bpf_pkg::ADDR_HOST_OUT: hostCtl    <= regWrData[4:0];
            bpf_pkg::ADDR_STATE:    stateCtl   <= regWrData;
            bpf_pkg::ADDR_FEATURE:  featureCtl <= regWrData;
            bpf_pkg::ADDR_PICKER:   picker     <= regWrData;
            bpf_pkg::ADDR_OL_THR:   olThr      <= regWrData;
            bpf_pkg::ADDR_OL_DLY:   olDly      <= regWrData;
            bpf_pkg::ADDR_CHG_SC:   chgSc      <= regWrData;
            bpf_pkg::ADDR_DSG_SC:   dsgSc      <= regWrData;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // register reads
   // ---------------------------------------------------------------
   assign statusWord = {3'h0, sleepPin, wdogFlag, faultFlag};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         unique case (regAddr)
            bpf_pkg::ADDR_STATUS:   regRdData <= statusWord;
            bpf_pkg::ADDR_HOST_OUT: regRdData <= {3'h0, hostCtl};
            bpf_pkg::ADDR_STATE:    regRdData <= stateCtl;
            bpf_pkg::ADDR_FEATURE:  regRdData <= featureCtl;
            bpf_pkg::ADDR_PICKER:   regRdData <= picker;
            bpf_pkg::ADDR_OL_THR:   regRdData <= olThr;
            bpf_pkg::ADDR_OL_DLY:   regRdData <= olDly;
            bpf_pkg::ADDR_CHG_SC:   regRdData <= chgSc;
            bpf_pkg::ADDR_DSG_SC:   regRdData <= dsgSc;
            default:                regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // blanking timers, counted in watchdog ticks
   // ---------------------------------------------------------------
   assign detect = {excessLoadDetect, chargeShortDetect, dischargeShortDetect};

   always_comb begin
      blankLim[0] = 11'(int'(dsgSc[3:0]) * TICKS_PER_SC);
      blankLim[1] = 11'(int'(chgSc[3:0]) * TICKS_PER_SC);
      blankLim[2] = 11'((bpf_pkg::OL_BASE_MS + bpf_pkg::OL_STEP_MS * int'(olDly[3:0])) * TICKS_PER_MS);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wdiPrev <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            blankCnt[i] <= 11'h000;
         end
      end else begin
         wdiPrev <= watchdogClockInput;
         for (int i = 0; i < 3; i++) begin
            if (!detect[i]) begin
               blankCnt[i] <= 11'h000;
            end else if (wdiTick && blankCnt[i] < blankLim[i]) begin
               blankCnt[i] <= blankCnt[i] + 11'h001;
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         faultSet[i] = detect[i] && (blankCnt[i] >= blankLim[i]);
      end
   end

   // set wins over the clear toggle so a fault in the clear cycle is kept
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         faultFlag <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (faultSet[i]) begin
               faultFlag[i] <= 1'b1;
            end else if (clrPulse) begin
               faultFlag[i] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // watchdog
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wdState      <= WD_WAIT;
         startCnt     <= 26'h0000000;
         startExpired <= 1'b0;
         gapCnt       <= 13'h0000;
      end else begin
         unique case (wdState)
            WD_WAIT: begin
               if (wdiTick) begin
                  wdState <= WD_RUN;
               end else if (!startExpired) begin
                  if (startCnt == 26'(STARTUP_CYCLES - 1)) begin
                     startExpired <= 1'b1;
                  end else begin
                     startCnt <= startCnt + 26'h0000001;
                  end
               end
               gapCnt <= 13'h0000;
            end
            WD_RUN: begin
               if (wdiTick) begin
                  gapCnt <= 13'h0000;
               end else if (gapCnt == 13'(STOP_CYCLES - 1)) begin
                  wdState <= WD_STOP;
               end else begin
                  gapCnt <= gapCnt + 13'h0001;
               end
            end
            WD_STOP: begin
               gapCnt <= 13'h0000;
               if (wdiTick) begin
                  wdState <= WD_RUN;
               end
            end
         endcase
      end
   end

   assign wdEvent  = (wdState == WD_WAIT && !wdiTick && !startExpired && startCnt == 26'(STARTUP_CYCLES - 1))
                  || (wdState == WD_RUN && !wdiTick && gapCnt == 13'(STOP_CYCLES - 1));
   // the fault condition itself releases when the clock runs again
   assign wdActive = (wdState == WD_STOP) || (wdState == WD_WAIT && startExpired);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wdogFlag <= 1'b0;
      end else if (wdEvent) begin
         wdogFlag <= 1'b1;
      end else if (clrPulse) begin
         wdogFlag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // alert
   // ---------------------------------------------------------------
   assign alertSet = (|(faultSet & ~faultFlag)) || wdEvent || (sleepPin != sleepPrev);

   // a read releases the alert only once the latches are cleared
   // the pin is captured during reset so a high pin at release is not a change
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sleepPrev <= sleepPin;
         alertPend <= 1'b0;
      end else begin
         sleepPrev <= sleepPin;
         if (alertSet) begin
            alertPend <= 1'b1;
         end else if (statusRead && faultFlag == 3'h0 && !wdogFlag) begin
            alertPend <= 1'b0;
         end
      end
   end

   assign alertOutputN = !alertPend;

   // ---------------------------------------------------------------
   // FET drives
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pmsStrap  <= 1'b0;
         strapDone <= 1'b0;
         initState <= 1'b1;
      end else begin
         if (!strapDone) begin
            pmsStrap  <= zeroVoltChargeSelect;
            strapDone <= 1'b1;
         end
         if (wrHit && regAddr == bpf_pkg::ADDR_HOST_OUT) begin
            initState <= 1'b0;
         end
      end
   end

   assign protOk = (faultFlag == 3'h0) && (faultSet == 3'h0) && !wdActive;

   always_comb begin
      if (initState) begin
         next_dsg = 1'b0;
         next_chg = pmsStrap && strapDone;
         next_zv  = 1'b0;
      end else begin
         next_dsg = hostCtl[bpf_pkg::HO_DSG];
         next_chg = hostCtl[bpf_pkg::HO_CHG];
         next_zv  = hostCtl[bpf_pkg::HO_ZERO_VOLT_CHARGE_FET_DRIVE];
      end
      if (!protOk) begin
         next_dsg = 1'b0;
         next_chg = 1'b0;
         next_zv  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dischargeFetDrive      <= 1'b0;
         chargeFetDrive         <= 1'b0;
         zeroVoltChargeFetDrive <= 1'b0;
      end else begin
         dischargeFetDrive      <= next_dsg;
         chargeFetDrive         <= next_chg;
         zeroVoltChargeFetDrive <= next_zv;
      end
   end

   // ---------------------------------------------------------------
   // monitor, balancing and auxiliary outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         openDrainOutput          <= 1'b0;
         thermistorDrive          <= 1'b0;
         elementCode              <= 2'h0;
         calibSelect              <= 2'h0;
         monitorEnable            <= 1'b0;
         refDirectRoute           <= 1'b0;
         refScaledRoute           <= 1'b0;
         balanceEnable            <= 4'h0;
         overloadThresholdSetting <= 5'h00;
         chargeShortSetting       <= 4'h0;
         dischargeShortSetting    <= 4'h0;
      end else begin
         openDrainOutput          <= hostCtl[bpf_pkg::HO_OPEN_DRAIN];
         thermistorDrive          <= featureCtl[bpf_pkg::FC_THERM];
         elementCode              <= picker[bpf_pkg::PK_CODE_LO +: 2];
         calibSelect              <= picker[bpf_pkg::PK_CAL_LO +: 2];
         monitorEnable            <= featureCtl[bpf_pkg::FC_MON_EN];
         refDirectRoute           <= featureCtl[bpf_pkg::FC_MON_EN] && picker[1:0] == 2'h0
                                  && picker[bpf_pkg::PK_CAL_LO +: 2] == bpf_pkg::CAL_REF_DIRECT;
         refScaledRoute           <= featureCtl[bpf_pkg::FC_MON_EN] && picker[1:0] == 2'h0
                                  && picker[bpf_pkg::PK_CAL_LO +: 2] == bpf_pkg::CAL_REF_SCALED;
         balanceEnable            <= picker[bpf_pkg::PK_BAL_LO +: 4];
         overloadThresholdSetting <= olThr[4:0];
         chargeShortSetting       <= chgSc[bpf_pkg::SC_THR_LO +: 4];
         dischargeShortSetting    <= dsgSc[bpf_pkg::SC_THR_LO +: 4];
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_ol_trip;
      @(posedge ref_clk) disable iff (rst)
      (excessLoadDetect && blankCnt[2] >= blankLim[2]) |=> faultFlag[2] && !dischargeFetDrive;
   endproperty
   a_ol_trip: assert property (p_ol_trip) else $error("overload past delay not latched");

   property p_sc_zero;
      @(posedge ref_clk) disable iff (rst)
      (dischargeShortDetect && dsgSc[3:0] == 4'h0) |=> faultFlag[0];
   endproperty
   a_sc_zero: assert property (p_sc_zero) else $error("zero short delay did not trip at once");

   property p_hold;
      @(posedge ref_clk) disable iff (rst)
      (faultFlag != 3'h0 && !clrPulse) |=> (faultFlag != 3'h0) && !chargeFetDrive;
   endproperty
   a_hold: assert property (p_hold) else $error("fault latch dropped without clear");

   property p_alert;
      @(posedge ref_clk) disable iff (rst)
      $rose(faultFlag[1]) |-> !alertOutputN;
   endproperty
   a_alert: assert property (p_alert) else $error("alert not asserted on fault");

   property p_restart;
      @(posedge ref_clk) disable iff (rst)
      !excessLoadDetect |=> blankCnt[2] == 11'h000;
   endproperty
   a_restart: assert property (p_restart) else $error("blanking counter not restarted");

   property p_wd_stop;
      @(posedge ref_clk) disable iff (rst)
      (wdState == WD_RUN && !wdiTick && gapCnt == 13'(STOP_CYCLES - 1))
         |=> wdogFlag ##1 (!dischargeFetDrive && !zeroVoltChargeFetDrive);
   endproperty
   a_wd_stop: assert property (p_wd_stop) else $error("watchdog gap did not shut FETs");

   property p_wd_resume;
      @(posedge ref_clk) disable iff (rst)
      (wdState == WD_STOP && wdiTick) |=> !wdActive && wdogFlag;
   endproperty
   a_wd_resume: assert property (p_wd_resume) else $error("watchdog resume mishandled");

   property p_init;
      @(posedge ref_clk) disable iff (rst)
      (initState && $past(initState) && $past(protOk)) |-> !dischargeFetDrive && chargeFetDrive == $past(pmsStrap);
   endproperty
   a_init: assert property (p_init) else $error("init FET state wrong");

   property p_therm;
      @(posedge ref_clk) disable iff (rst)
      (wrHit && regAddr == bpf_pkg::ADDR_FEATURE) |=> ##1 thermistorDrive == $past(regWrData[bpf_pkg::FC_THERM], 2);
   endproperty
   a_therm: assert property (p_therm) else $error("thermistor drive does not follow write");

   property p_ref;
      @(posedge ref_clk) disable iff (rst)
      (featureCtl[0] && picker[3:0] == 4'hc) |=> refDirectRoute && !refScaledRoute;
   endproperty
   a_ref: assert property (p_ref) else $error("reference route not selected");

   property p_release;
      @(posedge ref_clk) disable iff (rst)
      (statusRead && faultFlag == 3'h0 && !wdogFlag && !alertSet) |=> alertOutputN;
   endproperty
   a_release: assert property (p_release) else $error("status read did not release alert");
endmodule : bpf_fault_ctrl
`default_nettype wire

// file: tb/bpf_wdog_host.sv
// host side model: supplies the watchdog clock that times the blanking delays
// assumes: ref_clk is the device clock; the clock stands still (low) while run is low
`timescale 1ns/1ns
`default_nettype none
module bpf_wdog_host #(
   parameter int HALF = 4
) (
   // clock
   input  wire logic ref_clk,
   // control
   input  wire logic run,
   // watchdog clock to the device
   output logic      watchdogClockInput
);
   int phase;
   // ---------------------------------------------------------------
   // clock generator
   // ---------------------------------------------------------------
   // period stays well under the stop limit so a running clock never trips
   initial begin
      watchdogClockInput = 1'b0;
      phase = 0;
   end
   always @(posedge ref_clk) begin
      if (!run) begin
         watchdogClockInput <= 1'b0;
         phase <= 0;
      end else if (phase == HALF - 1) begin
         watchdogClockInput <= ~watchdogClockInput;
         phase <= 0;
      end else begin
         phase <= phase + 1;
      end
   end
endmodule : bpf_wdog_host
`default_nettype wire

// file: tb/tb_top.sv
// testbench: register tasks, fault, watchdog and control scenarios
// assumes: 50 MHz clock, shortened startup and stop counts, host watchdog model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic ref_clk, rst, regWr, regRd, run, watchdog_clock_input, dsd, csd, eld, sleepPin, strap;
   logic [7:0] regAddr, regWrData, regRdData, got;
   logic discharge_fet_drive, charge_fet_drive, zv, alertN, od, therm, mon, refD, refS;
   logic [1:0] code, cal;
   logic [3:0] bal, cs, ds;
   logic [4:0] olThr;
   int error_cnt, compares, cyc;

   bpf_fault_ctrl #(.STARTUP_CYCLES(200), .STOP_CYCLES(20), .TICKS_PER_MS(2), .TICKS_PER_SC(1)) u_bpf_fault_ctrl (
      .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .watchdogClockInput(watchdog_clock_input), .dischargeShortDetect(dsd), .chargeShortDetect(csd),
      .excessLoadDetect(eld), .sleepPin(sleepPin), .zeroVoltChargeSelect(strap), .dischargeFetDrive(discharge_fet_drive),
      .chargeFetDrive(charge_fet_drive), .zeroVoltChargeFetDrive(zv), .alertOutputN(alertN), .openDrainOutput(od),
      .thermistorDrive(therm), .elementCode(code), .calibSelect(cal), .monitorEnable(mon),
      .refDirectRoute(refD), .refScaledRoute(refS), .balanceEnable(bal), .overloadThresholdSetting(olThr),
      .chargeShortSetting(cs), .dischargeShortSetting(ds));
   bpf_wdog_host u_bpf_wdog_host (.ref_clk(ref_clk), .run(run), .watchdogClockInput(watchdog_clock_input));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      compares++;
      if (exp !== seen) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // a trailing idle edge keeps two strobes from landing in one time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a; regWrData <= d; regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      regAddr <= a; regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 got = regRdData;
      @(posedge ref_clk);
   endtask : rd
   task automatic ticks(input int n);
      repeat (n) @(posedge watchdog_clock_input);
      @(posedge ref_clk);
   endtask : ticks
   task automatic clr();
      wr(bpf_pkg::ADDR_HOST_OUT, 8'h1f);
      wr(bpf_pkg::ADDR_HOST_OUT, 8'h1e);
      repeat (2) @(posedge ref_clk);
   endtask : clr
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // the whole sequence needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst, strap} = 2'b11;
      {regWr, regRd, run, dsd, csd, eld, sleepPin} = '0;
      regAddr = 8'h00; regWrData = 8'h00; error_cnt = 0; compares = 0; cyc = 0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("init drives", 8'h14, {2'b0, discharge_fet_drive, charge_fet_drive, zv, alertN, od, therm});
      repeat (230) @(posedge ref_clk);
      chk("startup drives", 8'h00, {5'b0, discharge_fet_drive, charge_fet_drive, zv});
      chk("startup alert", 8'h00, {7'b0, alertN});
      rd(bpf_pkg::ADDR_STATUS); chk("startup status", 8'h08, got);
      run <= 1'b1;
      ticks(2);
      clr();
      rd(bpf_pkg::ADDR_STATUS); chk("status clear", 8'h00, got);
      chk("alert release", 8'h01, {7'b0, alertN});
      chk("host drives", 8'h0f, {4'b0, discharge_fet_drive, charge_fet_drive, zv, od});
      wr(bpf_pkg::ADDR_FEATURE, 8'h21);
      wr(bpf_pkg::ADDR_PICKER, 8'h0c);
      repeat (2) @(posedge ref_clk);
      chk("ref direct", 8'h1c, {3'b0, therm, mon, refD, refS, |code});
      wr(bpf_pkg::ADDR_PICKER, 8'ha9);
      repeat (2) @(posedge ref_clk);
      chk("picker", 8'ha9, {bal, cal, code});
      wr(bpf_pkg::ADDR_PICKER, 8'h58);
      repeat (2) @(posedge ref_clk);
      chk("ref scaled", 8'h52, {bal, 2'b0, refS, refD});
      wr(bpf_pkg::ADDR_OL_DLY, 8'h01);
      eld <= 1'b1; ticks(4); eld <= 1'b0; ticks(1); eld <= 1'b1; ticks(4);
      chk("ol blank", 8'h07, {5'b0, discharge_fet_drive, charge_fet_drive, zv});
      ticks(4);
      chk("ol trip", 8'h00, {4'b0, discharge_fet_drive, charge_fet_drive, zv, alertN});
      rd(bpf_pkg::ADDR_STATUS); chk("ol status", 8'h04, got);
      clr(); ticks(8);
      rd(bpf_pkg::ADDR_STATUS); chk("ol retrip", 8'h04, got);
      chk("retrip drives", 8'h00, {5'b0, discharge_fet_drive, charge_fet_drive, zv});
      eld <= 1'b0; clr();
      dsd <= 1'b1; repeat (3) @(posedge ref_clk); dsd <= 1'b0; repeat (20) @(posedge ref_clk);
      rd(bpf_pkg::ADDR_STATUS); chk("dsg short", 8'h01, got);
      chk("short drives", 8'h00, {5'b0, discharge_fet_drive, charge_fet_drive, zv});
      clr();
      wr(bpf_pkg::ADDR_CHG_SC, 8'h53);
      wr(bpf_pkg::ADDR_DSG_SC, 8'ha0);
      wr(bpf_pkg::ADDR_OL_THR, 8'h1f);
      @(posedge ref_clk);
      chk("short thr", 8'h5a, {cs, ds});
      chk("ol thr", 8'h1f, {3'b0, olThr});
      csd <= 1'b1; ticks(1);
      rd(bpf_pkg::ADDR_STATUS); chk("chg blank", 8'h00, got);
      ticks(4); csd <= 1'b0;
      rd(bpf_pkg::ADDR_STATUS); chk("chg short", 8'h02, got);
      clr();
      run <= 1'b0; repeat (40) @(posedge ref_clk);
      chk("wd stop", 8'h00, {5'b0, discharge_fet_drive, charge_fet_drive, zv});
      run <= 1'b1; ticks(3);
      rd(bpf_pkg::ADDR_STATUS); chk("wd latched", 8'h08, got);
      clr();
      chk("wd cleared", 8'h07, {5'b0, discharge_fet_drive, charge_fet_drive, zv});
      rd(bpf_pkg::ADDR_STATUS); chk("wd status", 8'h00, got);
      sleepPin <= 1'b1; repeat (3) @(posedge ref_clk);
      chk("sleep alert", 8'h00, {7'b0, alertN});
      rd(bpf_pkg::ADDR_STATUS); chk("sleep status", 8'h10, got);
      chk("sleep release", 8'h01, {7'b0, alertN});
      rd(8'h20); chk("unmapped", 8'h00, got);
      strap <= 1'b0; rst <= 1'b1; repeat (2) @(posedge ref_clk);
      rst <= 1'b0; repeat (3) @(posedge ref_clk);
      chk("ground strap", 8'h01, {5'b0, discharge_fet_drive, charge_fet_drive, alertN});
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
